// file: core/tcp_pkg.sv
package tcp_pkg;

  // ==========================================================
  // Register bus request
  typedef struct packed {
    logic [3:0] addr;   // Byte register index
    logic [7:0] wdata;  // Write data
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
  } tcp_bus_s;

  // ==========================================================
  // Register offsets (byte registers, index = address)
  localparam logic [3:0] ADDR_CTRL_SECOND = 4'h0;
  localparam logic [3:0] ADDR_CTRL_FIRST  = 4'h1;
  localparam logic [3:0] ADDR_STATUS      = 4'h2;
  localparam logic [3:0] ADDR_CAP1_HI     = 4'h3;
  localparam logic [3:0] ADDR_CAP1_LO     = 4'h4;
  localparam logic [3:0] ADDR_CMP1_HI     = 4'h5;
  localparam logic [3:0] ADDR_CMP1_LO     = 4'h6;
  localparam logic [3:0] ADDR_CNT_HI      = 4'h7;
  localparam logic [3:0] ADDR_CNT_LO      = 4'h8;
  localparam logic [3:0] ADDR_ACNT_HI     = 4'h9;
  localparam logic [3:0] ADDR_ACNT_LO     = 4'hA;
  localparam logic [3:0] ADDR_CAP2_HI     = 4'hB;
  localparam logic [3:0] ADDR_CAP2_LO     = 4'hC;
  localparam logic [3:0] ADDR_CMP2_HI     = 4'hD;
  localparam logic [3:0] ADDR_CMP2_LO     = 4'hE;

  // ==========================================================
  // First control register fields
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_CMP_IRQ_EN = 6;
  localparam int C1_OVF_IRQ_EN = 5;
  localparam int C1_FORCE2     = 4;
  localparam int C1_FORCE1     = 3;
  localparam int C1_LEVEL2     = 2;
  localparam int C1_TRIG_EDGE  = 1;
  localparam int C1_LEVEL1     = 0;

  // Second control register fields
  localparam int C2_PIN1_EN    = 7;
  localparam int C2_PIN2_EN    = 6;
  localparam int C2_PULSE_SEL  = 5;
  localparam int C2_PWM_SEL    = 4;
  localparam int C2_CLK_SEL_HI = 3;
  localparam int C2_CLK_SEL_LO = 2;
  localparam int C2_CAP2_EDGE  = 1;
  localparam int C2_EXT_EDGE   = 0;

  // Status flag positions
  localparam int F_CAPTURE_FLAG_ONE = 0;
  localparam int F_OCF1 = 1;
  localparam int F_TOF  = 2;
  localparam int F_CAPTURE_FLAG_TWO = 3;
  localparam int F_OCF2 = 4;

  // Status register bit positions
  localparam int S_CAPTURE_FLAG_ONE = 7;
  localparam int S_OCF1 = 6;
  localparam int S_TOF  = 5;
  localparam int S_CAPTURE_FLAG_TWO = 4;
  localparam int S_OCF2 = 3;

  // ==========================================================
  // Clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;

  // ==========================================================
  // Reset and load values
  localparam logic [15:0] CMP_RESET    = 16'h8000;
  localparam logic [15:0] CNT_RESET    = 16'hFFFC;
  localparam logic [15:0] CAP1_PULSE   = 16'hFFFD;
  localparam logic [15:0] CNT_TOP      = 16'hFFFF;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [2:0]  PSC_RESET    = 3'h0;
  localparam logic [2:0]  PSC_DIV4_END = 3'h3;
  localparam logic [2:0]  PSC_DIV8_END = 3'h7;

  // Operating modes
  typedef enum logic [1:0] {MODE_NORMAL, MODE_PULSE, MODE_PWM} tcp_mode_e;

endpackage

// file: core/tcp_timer_unit.sv
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

module tcp_timer_unit (
  input  wire logic              I_REF_CLK,      // CPU clock, 25 MHz
  input  wire logic              I_RESETN,       // Async reset, active low
  input  wire tcp_pkg::tcp_bus_s I_BUS,          // Register request
  output logic [7:0]             O_RDATA,        // Read data, cycle after strobe
  input  wire logic              I_GLOBAL_MASK,  // CPU interrupt mask bit
  output logic                   O_TIMER_IRQ,    // Shared timer interrupt
  input  wire logic              I_TRIGGER_PIN,  // Capture one / pulse trigger
  input  wire logic              I_CAPTURE2_PIN, // Second capture input
  input  wire logic              I_EXT_CLK,      // External timer clock
  output logic [1:0]             O_CMP_OUT,      // Compare pin levels
  output logic [1:0]             O_CMP_OE        // Compare pin drive enables
);
  import tcp_pkg::*;

  // ==========================================================
  // State
  logic [7:0]  ctrl_first;
  logic [7:0]  ctrl_second;
  logic [15:0] cmp_val [2];
  logic [15:0] cap_val [2];
  logic [1:0]  cmp_block;
  logic [1:0]  cap_hold;
  logic [15:0] cnt;
  logic        cnt_upd;
  logic [2:0]  psc;
  logic [4:0]  flags;
  logic [4:0]  clr_arm;
  logic [7:0]  cnt_lo_buf;
  logic        cnt_seq;
  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic [2:0]  sync3;
  // Decoded
  tcp_mode_e   mode;
  logic [1:0]  clk_sel;
  logic        tick;
  logic        trig_edge;
  logic        cap2_edge;
  logic        ext_edge;
  logic [1:0]  match_evt;
  logic [1:0]  force_evt;
  logic        cnt_load;
  logic        cnt_wr_reset;
  logic [4:0]  flag_set;
  logic [4:0]  flag_clr;
  logic [4:0]  low_access;
  logic        st_read;
  logic [7:0]  next_rdata;

  // Any access to a given register
  function automatic logic hit(input tcp_bus_s b, input logic [3:0] a);
    return (b.wr || b.rd) && (b.addr == a);
  endfunction
  // Compare condition: plus one for slow clocks, counter runs one count late
  function automatic logic cmp_hit(input logic [15:0] c, input logic [15:0] v, input logic late);
    return late ? (c == 16'(v + 16'h0001)) : (c == v);
  endfunction

  // ==========================================================
  // Mode decode; PWM select masks pulse select
  assign mode    = ctrl_second[C2_PWM_SEL] ? MODE_PWM :
                   (ctrl_second[C2_PULSE_SEL] ? MODE_PULSE : MODE_NORMAL);
  assign clk_sel = ctrl_second[C2_CLK_SEL_HI:C2_CLK_SEL_LO];

  // ==========================================================
  // Pin synchronisers; stages two and three feed edge logic
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else begin
      sync1 <= {I_EXT_CLK, I_CAPTURE2_PIN, I_TRIGGER_PIN};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // Edge select bit high picks rising edges
  assign trig_edge = ctrl_first[C1_TRIG_EDGE] ? (sync2[0] && !sync3[0]) : (!sync2[0] && sync3[0]);
  assign cap2_edge = ctrl_second[C2_CAP2_EDGE] ? (sync2[1] && !sync3[1]) : (!sync2[1] && sync3[1]);
  assign ext_edge  = ctrl_second[C2_EXT_EDGE] ? (sync2[2] && !sync3[2]) : (!sync2[2] && sync3[2]);

  // ==========================================================
  // Prescaler; free-running so a mid-count select change only stretches or shortens one period
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      psc <= PSC_RESET;
    end else begin
      psc <= 3'(psc + 3'h1);
    end
  end
  // Timer tick enable
  always_comb begin
    case (clk_sel)
      CLK_DIV2: tick = psc[0];
      CLK_DIV4: tick = (psc[1:0] == PSC_DIV4_END[1:0]);
      CLK_DIV8: tick = (psc == PSC_DIV8_END);
      CLK_EXT:  tick = ext_edge;
      default:  tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Match events, one per counter update
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      match_evt[i] = cnt_upd && !cmp_block[i] && cmp_hit(cnt, cmp_val[i], clk_sel != CLK_DIV2);
    end
  end

  // Forced output only in normal mode
  assign force_evt[0] = I_BUS.wr && I_BUS.addr == ADDR_CTRL_FIRST && I_BUS.wdata[C1_FORCE1]
                        && mode == MODE_NORMAL;
  assign force_evt[1] = I_BUS.wr && I_BUS.addr == ADDR_CTRL_FIRST && I_BUS.wdata[C1_FORCE2]
                        && mode == MODE_NORMAL;
  assign cnt_wr_reset = I_BUS.wr && (I_BUS.addr == ADDR_CNT_LO || I_BUS.addr == ADDR_ACNT_LO);
  assign cnt_load     = cnt_wr_reset || (mode == MODE_PULSE && trig_edge) || (mode == MODE_PWM && match_evt[1]);

  // ==========================================================
  // Free-running counter
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cnt     <= CNT_RESET;
      cnt_upd <= 1'b0;
    end else begin
      cnt_upd <= tick || cnt_load;
      if (cnt_load) begin
        cnt <= CNT_RESET;
      end else if (tick) begin
        cnt <= 16'(cnt + 16'h0001);
      end
    end
  end

  // ==========================================================
  // Control registers; force bits are strobes and read as zero
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_first  <= CTRL_RESET;
      ctrl_second <= CTRL_RESET;
    end else if (I_BUS.wr) begin
      if (I_BUS.addr == ADDR_CTRL_FIRST) begin
        ctrl_first <= I_BUS.wdata & ~(8'h01 << C1_FORCE1) & ~(8'h01 << C1_FORCE2);
      end
      if (I_BUS.addr == ADDR_CTRL_SECOND) begin
        ctrl_second <= I_BUS.wdata;
      end
    end
  end

  // ==========================================================
  // Compare values; only software changes them
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cmp_val[0] <= CMP_RESET;
      cmp_val[1] <= CMP_RESET;
      cmp_block  <= 2'h0;
    end else if (I_BUS.wr) begin
      case (I_BUS.addr)
        ADDR_CMP1_HI: begin
          cmp_val[0][15:8] <= I_BUS.wdata;
          cmp_block[0]     <= 1'b1;
        end
        ADDR_CMP1_LO: begin
          cmp_val[0][7:0] <= I_BUS.wdata;
          cmp_block[0]    <= 1'b0;
        end
        ADDR_CMP2_HI: begin
          cmp_val[1][15:8] <= I_BUS.wdata;
          cmp_block[1]     <= 1'b1;
        end
        ADDR_CMP2_LO: begin
          cmp_val[1][7:0] <= I_BUS.wdata;
          cmp_block[1]    <= 1'b0;
        end
        default: cmp_block <= cmp_block;
      endcase
    end
  end

  // ==========================================================
  // Captures; high byte read freezes until low byte read, except the pulse-mode load of capture one
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cap_val[0] <= 16'h0000;
      cap_val[1] <= 16'h0000;
      cap_hold   <= 2'h0;
    end else begin
      if (mode == MODE_PULSE && trig_edge) begin
        cap_val[0] <= CAP1_PULSE;
      end else if (mode == MODE_NORMAL && trig_edge && !cap_hold[0]) begin
        cap_val[0] <= cnt;
      end
      if (cap2_edge && !cap_hold[1]) begin
        cap_val[1] <= cnt;
      end
      if (I_BUS.rd && I_BUS.addr == ADDR_CAP1_HI) begin
        cap_hold[0] <= 1'b1;
      end else if (I_BUS.rd && I_BUS.addr == ADDR_CAP1_LO) begin
        cap_hold[0] <= 1'b0;
      end
      if (I_BUS.rd && I_BUS.addr == ADDR_CAP2_HI) begin
        cap_hold[1] <= 1'b1;
      end else if (I_BUS.rd && I_BUS.addr == ADDR_CAP2_LO) begin
        cap_hold[1] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Flag set sources per mode
  always_comb begin
    flag_set         = 5'h00;
    flag_set[F_OCF1] = mode == MODE_NORMAL && match_evt[0];
    flag_set[F_OCF2] = mode != MODE_PWM && match_evt[1];
    flag_set[F_TOF]  = tick && !cnt_load && cnt == CNT_TOP;
    flag_set[F_CAPTURE_FLAG_TWO] = cap2_edge && !cap_hold[1];
    flag_set[F_CAPTURE_FLAG_ONE] = (mode == MODE_NORMAL && trig_edge && !cap_hold[0])
                       || (mode == MODE_PULSE && trig_edge)
                       || (mode == MODE_PWM && match_evt[1]);
  end
  assign st_read              = I_BUS.rd && I_BUS.addr == ADDR_STATUS;
  assign low_access[F_CAPTURE_FLAG_ONE]   = hit(I_BUS, ADDR_CAP1_LO);
  assign low_access[F_OCF1]   = hit(I_BUS, ADDR_CMP1_LO);
  assign low_access[F_TOF]    = hit(I_BUS, ADDR_CNT_LO);
  assign low_access[F_CAPTURE_FLAG_TWO]   = hit(I_BUS, ADDR_CAP2_LO);
  assign low_access[F_OCF2]   = hit(I_BUS, ADDR_CMP2_LO);
  assign flag_clr             = clr_arm & low_access;

  // ==========================================================
  // Sticky flags, two-step clear; a set in the clear cycle wins
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      flags   <= 5'h00;
      clr_arm <= 5'h00;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
      if (st_read) begin
        clr_arm <= (clr_arm | flags) & ~low_access;
      end else begin
        clr_arm <= clr_arm & ~low_access;
      end
    end
  end

  // ==========================================================
  // Compare pin latches, low through reset
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_CMP_OUT <= 2'h0;
    end else begin
      case (mode)
        MODE_NORMAL: begin
          for (int i = 0; i < 2; i++) begin
            if ((match_evt[i] || force_evt[i]) && ctrl_second[C2_PIN1_EN - i]) begin
              // Force takes the level written beside it, not the stale one
              O_CMP_OUT[i] <= force_evt[i] ? I_BUS.wdata[i == 0 ? C1_LEVEL1 : C1_LEVEL2]
                                           : ctrl_first[i == 0 ? C1_LEVEL1 : C1_LEVEL2];
            end
          end
        end
        MODE_PULSE: begin
          if (trig_edge) begin
            O_CMP_OUT[0] <= ctrl_first[C1_LEVEL2];
          end else if (match_evt[0]) begin
            O_CMP_OUT[0] <= ctrl_first[C1_LEVEL1];
          end
        end
        MODE_PWM: begin
          if (match_evt[1]) begin
            O_CMP_OUT[0] <= ctrl_first[C1_LEVEL2];
          end else if (match_evt[0]) begin
            O_CMP_OUT[0] <= ctrl_first[C1_LEVEL1];
          end
        end
        default: O_CMP_OUT <= O_CMP_OUT;
      endcase
    end
  end
  // Channel two drives no waveform in pulse or PWM mode
  assign O_CMP_OE[0] = ctrl_second[C2_PIN1_EN];
  assign O_CMP_OE[1] = ctrl_second[C2_PIN2_EN] && mode == MODE_NORMAL;

  // ==========================================================
  // Shared interrupt, gated by the CPU mask
  assign O_TIMER_IRQ = !I_GLOBAL_MASK && (
                       (ctrl_first[C1_CMP_IRQ_EN] && (flags[F_OCF1] || flags[F_OCF2]))
                    || (ctrl_first[C1_CAP_IRQ_EN] && (flags[F_CAPTURE_FLAG_ONE] || flags[F_CAPTURE_FLAG_TWO]))
                    || (ctrl_first[C1_OVF_IRQ_EN] && flags[F_TOF]));

  // ==========================================================
  // Read mux; counter high read freezes low byte for a clean 16-bit read
  always_comb begin
    case (I_BUS.addr)
      ADDR_CTRL_FIRST:  next_rdata = ctrl_first;
      ADDR_CTRL_SECOND: next_rdata = ctrl_second;
      ADDR_STATUS:      next_rdata = {flags[F_CAPTURE_FLAG_ONE], flags[F_OCF1], flags[F_TOF], flags[F_CAPTURE_FLAG_TWO],
                                      flags[F_OCF2], 3'h0};
      ADDR_CAP1_HI:     next_rdata = cap_val[0][15:8];
      ADDR_CAP1_LO:     next_rdata = cap_val[0][7:0];
      ADDR_CMP1_HI:     next_rdata = cmp_val[0][15:8];
      ADDR_CMP1_LO:     next_rdata = cmp_val[0][7:0];
      ADDR_CAP2_HI:     next_rdata = cap_val[1][15:8];
      ADDR_CAP2_LO:     next_rdata = cap_val[1][7:0];
      ADDR_CMP2_HI:     next_rdata = cmp_val[1][15:8];
      ADDR_CMP2_LO:     next_rdata = cmp_val[1][7:0];
      ADDR_CNT_HI,
      ADDR_ACNT_HI:     next_rdata = cnt[15:8];
      ADDR_CNT_LO,
      ADDR_ACNT_LO:     next_rdata = cnt_seq ? cnt_lo_buf : cnt[7:0];
      default:          next_rdata = 8'h00;
    endcase
  end
  // Read data register and counter read buffer
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA    <= 8'h00;
      cnt_lo_buf <= 8'h00;
      cnt_seq    <= 1'b0;
    end else if (I_BUS.rd) begin
      O_RDATA <= next_rdata;
      if ((I_BUS.addr == ADDR_CNT_HI || I_BUS.addr == ADDR_ACNT_HI) && !cnt_seq) begin
        cnt_lo_buf <= cnt[7:0];
        cnt_seq    <= 1'b1;
      end else if (I_BUS.addr == ADDR_CNT_LO || I_BUS.addr == ADDR_ACNT_LO) begin
        cnt_seq <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESETN);

  AST_CMP_SW_ONLY: assert property (
    $changed(cmp_val[0]) |-> $past(I_BUS.wr && (I_BUS.addr == ADDR_CMP1_HI || I_BUS.addr == ADDR_CMP1_LO)))
    else $error("compare value one changed without a write");
  AST_HI_INHIBIT: assert property (
    (I_BUS.wr && I_BUS.addr == ADDR_CMP2_HI) ##1 (!(I_BUS.wr && I_BUS.addr == ADDR_CMP2_LO))[*2] |=> !match_evt[1])
    else $error("channel two compared while high byte pending");
  AST_OCF1_SOURCE: assert property (
    $rose(flags[F_OCF1]) |-> $past(mode == MODE_NORMAL && match_evt[0]))
    else $error("match flag one set outside normal match");
  AST_PWM_NO_FLAG: assert property (
    mode == MODE_PWM && $past(mode == MODE_PWM) |-> !$rose(flags[F_OCF2]))
    else $error("match flag two set in PWM mode");
  AST_IRQ_MASK: assert property (
    I_GLOBAL_MASK |-> !O_TIMER_IRQ)
    else $error("interrupt raised while masked");
  AST_IRQ_CMP: assert property (
    !I_GLOBAL_MASK && ctrl_first[C1_CMP_IRQ_EN] && flags[F_OCF2] |-> O_TIMER_IRQ)
    else $error("compare interrupt missing");
  AST_PULSE_TRIG: assert property (
    mode == MODE_PULSE && trig_edge && !cnt_wr_reset
      |=> cnt == CNT_RESET && cap_val[0] == CAP1_PULSE && flags[F_CAPTURE_FLAG_ONE] && O_CMP_OUT[0] == $past(ctrl_first[C1_LEVEL2]))
    else $error("pulse trigger did not load counter, capture, flag and pin");
  AST_PWM_RELOAD: assert property (
    mode == MODE_PWM && match_evt[1] |=> cnt == CNT_RESET && flags[F_CAPTURE_FLAG_ONE])
    else $error("PWM period did not restart");
  AST_FLAG_CLEAR: assert property (
    $fell(flags[F_OCF1]) |-> $past(clr_arm[F_OCF1] && low_access[F_OCF1]))
    else $error("match flag one cleared without status read and low access");
  AST_FORCE: assert property (
    force_evt[0] && ctrl_second[C2_PIN1_EN] |=> O_CMP_OUT[0] == ctrl_first[C1_LEVEL1])
    else $error("forced level not copied to pin one");

endmodule

// file: test/tcp_pin_model.sv
`timescale 1ns/1ps
module tcp_pin_model (
  input  wire logic       i_clk,     // Reference clock
  input  wire logic [1:0] i_cmp_out, // Compare pin latches
  input  wire logic [1:0] i_cmp_oe,  // Compare pin enables
  output logic            o_trig,    // Trigger pin
  output logic            o_cap2,    // Second capture pin
  output logic            o_ext      // External timer clock
);
  // ==========================================================
  // Pad seen outside, pull-up when not driven
  logic [1:0] pad;
  assign pad = (i_cmp_out & i_cmp_oe) | ~i_cmp_oe;

  // Idle levels
  initial begin
    o_trig = 1'b0;
    o_cap2 = 1'b0;
    o_ext  = 1'b0;
  end

  // ==========================================================
  // Capture pins, changed right after an edge
  task automatic set_pin(input int which, input logic v);
    @(posedge i_clk);
    if (which == 0) begin
      o_trig <= v;
    end else begin
      o_cap2 <= v;
    end
  endtask

  // Slow ticks, well under a quarter of the clock rate
  task automatic ext_ticks(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_ext <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ext <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule

// file: test/timer_compare_pulse_unit_tb.sv
`timescale 1ns/1ps
module timer_compare_pulse_unit_tb;
  import tcp_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       gmask;
  logic       trig;
  logic       cap2;
  logic       ext;
  logic       irq;
  tcp_bus_s   bus;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [1:0] cmp_out;
  logic [1:0] cmp_oe;
  int         err_total;
  int         cmp_count;

  // ==========================================================
  // Block and far side
  tcp_timer_unit i_tcp_timer_unit (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_BUS(bus), .O_RDATA(rdata),
    .I_GLOBAL_MASK(gmask), .O_TIMER_IRQ(irq), .I_TRIGGER_PIN(trig), .I_CAPTURE2_PIN(cap2),
    .I_EXT_CLK(ext), .O_CMP_OUT(cmp_out), .O_CMP_OE(cmp_oe));
  tcp_pin_model i_tcp_pin_model (.i_clk(clk), .i_cmp_out(cmp_out), .i_cmp_oe(cmp_oe),
    .o_trig(trig), .o_cap2(cap2), .o_ext(ext));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // Bus cycles; read data valid from the cycle after the strobe until the next read
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic w16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(4'(a + 4'h1), v[7:0]);
  endtask

  // ==========================================================
  // Comparison helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic c16(input string n, input logic [3:0] a, input logic [15:0] e);
    rd(a, d);
    chk(n, e[15:8], d);
    rd(4'(a + 4'h1), d);
    chk(n, e[7:0], d);
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    rd(ADDR_STATUS, d);
    chk("status", e, d & m);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a pin level; a hang ends the run
  task automatic wait_pin(input int b, input logic v);
    int i;
    i = 0;
    while (cmp_out[b] !== v) begin
      hold(1);
      i++;
      if (i > 200) begin
        err_total++;
        $display("ERROR pin%0d expected %b seen %b", b, v, cmp_out[b]);
        test_done();
      end
    end
  endtask
  task automatic do_reset(input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    hold(n);
    @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("pins", 8'h00, {6'h00, cmp_out});
    c16("cmp1", ADDR_CMP1_HI, 16'h8000);
    c16("cmp2", ADDR_CMP2_HI, 16'h8000);
    rd(4'hF, d);
    chk("unmapped", 8'h00, d);
    $display("TEST reset done");
  endtask

  task automatic t_match();
    do_reset(2);
    wr(ADDR_CTRL_SECOND, 8'h84);
    wr(ADDR_CTRL_FIRST, 8'h41);
    w16(ADDR_CMP1_HI, 16'h0006);
    w16(ADDR_CMP2_HI, 16'h0006);
    wr(ADDR_CNT_LO, 8'h00);
    wait_pin(0, 1'b1);
    chk("oe", 8'h01, {6'h00, cmp_oe});
    chk("pin2", 8'h00, {7'h00, cmp_out[1]});
    st(8'h58, 8'h48);
    chk("irq", 8'h01, {7'h00, irq});
    @(posedge clk);
    gmask <= 1'b1;
    hold(2);
    chk("irq", 8'h00, {7'h00, irq});
    @(posedge clk);
    gmask <= 1'b0;
    rd(ADDR_CMP1_LO, d);
    hold(1);
    st(8'h48, 8'h08);
    wr(ADDR_CMP2_LO, 8'h06);
    hold(1);
    st(8'h48, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    $display("TEST match done");
  endtask

  // External ticks make the count exact
  task automatic t_ext();
    do_reset(2);
    wr(ADDR_CTRL_SECOND, 8'h8D);
    wr(ADDR_CTRL_FIRST, 8'h01);
    w16(ADDR_CMP1_HI, 16'h0002);
    wr(ADDR_CNT_LO, 8'h00);
    i_tcp_pin_model.ext_ticks(6);
    hold(8);
    chk("pin1", 8'h00, {7'h00, cmp_out[0]});
    i_tcp_pin_model.ext_ticks(1);
    hold(8);
    chk("pin1", 8'h01, {7'h00, cmp_out[0]});
    $display("TEST ext done");
  endtask

  task automatic t_inhibit();
    do_reset(2);
    wr(ADDR_CTRL_SECOND, 8'h04);
    wr(ADDR_CMP2_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h00);
    hold(30);
    st(8'h08, 8'h00);
    wr(ADDR_CMP2_LO, 8'h20);
    hold(60);
    st(8'h08, 8'h08);
    $display("TEST inhibit done");
  endtask

  task automatic t_force();
    do_reset(2);
    wr(ADDR_CTRL_SECOND, 8'hC4);
    wr(ADDR_CTRL_FIRST, 8'h1D);
    hold(3);
    chk("pin1", 8'h01, {7'h00, cmp_out[0]});
    chk("pin2", 8'h01, {7'h00, cmp_out[1]});
    st(8'h48, 8'h00);
    wr(ADDR_CTRL_SECOND, 8'hE4);
    wr(ADDR_CTRL_FIRST, 8'h08);
    hold(3);
    chk("pin1", 8'h01, {7'h00, cmp_out[0]});
    chk("oe2", 8'h00, {7'h00, cmp_oe[1]});
    $display("TEST force done");
  endtask

  task automatic t_pulse();
    do_reset(2);
    wr(ADDR_CTRL_FIRST, 8'h86);
    w16(ADDR_CMP1_HI, 16'h0008);
    wr(ADDR_CTRL_SECOND, 8'hA6);
    i_tcp_pin_model.set_pin(0, 1'b1);
    wait_pin(0, 1'b1);
    c16("cap1", ADDR_CAP1_HI, 16'hFFFD);
    st(8'hC0, 8'h80);
    chk("irq", 8'h01, {7'h00, irq});
    wait_pin(0, 1'b0);
    st(8'h40, 8'h00);
    i_tcp_pin_model.set_pin(1, 1'b1);
    hold(8);
    st(8'h10, 8'h10);
    c16("cmp1", ADDR_CMP1_HI, 16'h0008);
    $display("TEST pulse done");
  endtask

  // Both mode bits set; the waveform must still repeat
  task automatic t_pwm();
    do_reset(2);
    wr(ADDR_CTRL_SECOND, 8'hB4);
    wr(ADDR_CTRL_FIRST, 8'h01);
    w16(ADDR_CMP1_HI, 16'h0004);
    w16(ADDR_CMP2_HI, 16'h000A);
    wr(ADDR_CNT_LO, 8'h00);
    wait_pin(0, 1'b1);
    wait_pin(0, 1'b0);
    wait_pin(0, 1'b1);
    st(8'hC8, 8'h80);
    $display("TEST pwm done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    gmask = 1'b0;
    bus = '0;
    err_total = 0;
    cmp_count = 0;
    do_reset(20);
    t_reset();
    t_match();
    t_ext();
    t_inhibit();
    t_force();
    t_pulse();
    t_pwm();
    test_done();
  end
endmodule
